// ---- verilog/cmp_cfg.svh ----
// Purpose: offsets, field positions, reset values and counts of the comparator control block
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH

`define CMP_NUM 2
`define CMP_STRIDE 8'h10
`define CMP_CTRL_A_OFF 8'h00
`define CMP_CTRL_B_OFF 8'h04
`define CMP_FLAG_OFF 8'h40
`define CMP_MIRROR_OFF 8'h44
`define CMP_PINCFG_OFF 8'h48

`define CTRL_A_ON_BIT 7
`define CTRL_A_RESULT_BIT 6
`define CTRL_A_OE_BIT 5
`define CTRL_A_POL_BIT 4
`define CTRL_A_SP_BIT 2
`define CTRL_A_HYS_BIT 1
`define CTRL_A_SYNC_BIT 0
`define CTRL_A_WMASK 8'hb7
`define CTRL_A_RESET 8'h04

`define CTRL_B_RISE_BIT 7
`define CTRL_B_FALL_BIT 6
`define CTRL_B_PCH_LSB 4
`define CTRL_B_NCH_LSB 0
`define CTRL_B_WMASK 8'hf3
`define CTRL_B_RESET 8'h00

`define PINCFG_DIR_BIT 0
`define PINCFG_RESET 8'h01
`define PORT_LATCH_BIT 1

`define INSTR_DIV 4
`define INSTR_CNT_W 2

`endif

// ---- verilog/cmp_pkg.sv ----
// Purpose: types shared by the comparator control block
// Assumes: nothing
// Notes: constants live in cmp_cfg.svh
package cmp_pkg;
  typedef enum logic [1:0] {
    PLUS_PIN = 2'b00,
    PLUS_DAC = 2'b01,
    PLUS_REF2 = 2'b10,
    PLUS_GND = 2'b11
  } plus_sel_t;

  typedef enum logic [1:0] {
    AXI_IDLE = 2'b00,
    AXI_RESP = 2'b01
  } axi_state_t;
endpackage

// ---- verilog/cmp_channel.sv ----
// Purpose: one comparator's digital path: sync, polarity, latch, timer sync, edge detect
// Assumes: raw_result is asynchronous to aclk
// Notes: timer clock arrives as a pin and is sampled, not used as a clock
`include "cmp_cfg.svh"

module cmp_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw_result,
  input wire logic comparator_on,
  input wire logic output_invert,
  input wire logic timer_sync_enable,
  input wire logic rise_irq_enable,
  input wire logic fall_irq_enable,
  input wire logic instr_tick,
  input wire logic timer_clk_fall,
  output logic compare_result,
  output logic pin_result,
  output logic sync_result,
  output logic edge_event
);
  logic meta_reg;
  logic raw_sync_reg;
  logic final_reg;
  logic prev_reg;
  logic latched_reg;
  logic timer_reg;
  logic final_now;

  // ****************************************
  // Input synchroniser
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      raw_sync_reg <= 1'b0;
    end else begin
      meta_reg <= raw_result;
      raw_sync_reg <= meta_reg;
    end
  end

  // Disabled comparator reads low before polarity
  assign final_now = (raw_sync_reg & comparator_on) ^ output_invert;

  // ****************************************
  // Instruction-cycle latch and timer sync
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_reg <= 1'b0;
    end else if (instr_tick) begin
      latched_reg <= final_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= 1'b0;
    end else if (timer_clk_fall) begin
      timer_reg <= latched_reg;
    end
  end

  // ****************************************
  // Edge detectors
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      final_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      final_reg <= final_now;
      prev_reg <= final_reg;
    end
  end

  assign edge_event = (rise_irq_enable & final_reg & ~prev_reg)
                    | (fall_irq_enable & ~final_reg & prev_reg);
  assign compare_result = latched_reg;
  assign pin_result = final_reg;
  assign sync_result = timer_sync_enable ? timer_reg : latched_reg;
endmodule

// ---- verilog/analog_comparator_control.sv ----
// Purpose: control registers and digital logic around two analog comparators
// Assumes: AXI4-Lite slave on aclk (40 MHz); analog results and timer clock are async pins
// Notes: analog controls are plain level outputs to the analog macro
`include "cmp_cfg.svh"

module analog_comparator_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] raw_result,
  input wire logic [1:0] timer_clk_pin,
  output logic [1:0] analog_enable,
  output logic [1:0] speed_select_out,
  output logic [1:0] hysteresis_out,
  output logic [3:0] plus_route,
  output logic [3:0] minus_route,
  output logic [1:0] inputs_connect,
  output logic [1:0] result_pin_out,
  output logic [1:0] result_pin_oe_n,
  output logic [1:0] gate_source,
  output logic [1:0] shutdown_source,
  output logic [1:0] compare_irq_flag
);
  logic [7:0] ctrl_a_reg [2];
  logic [7:0] ctrl_b_reg [2];
  logic [7:0] pincfg_reg [2];
  logic [1:0] flag_reg;
  logic [`INSTR_CNT_W-1:0] div_reg;
  logic instr_tick;
  logic [1:0] tclk_meta_reg;
  logic [1:0] tclk_sync_reg;
  logic [1:0] tclk_prev_reg;
  logic [1:0] compare_result;
  logic [1:0] pin_result;
  logic [1:0] sync_result;
  logic [1:0] edge_event;
  cmp_pkg::axi_state_t wr_state_reg;
  cmp_pkg::axi_state_t rd_state_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic [1:0] flag_clear;

  // ****************************************
  // Instruction cycle enable
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `INSTR_CNT_W'(1);
    end
  end
  assign instr_tick = (div_reg == `INSTR_CNT_W'(`INSTR_DIV - 1));

  // ****************************************
  // Gate timer clock falling edge
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tclk_meta_reg <= 2'h0;
      tclk_sync_reg <= 2'h0;
      tclk_prev_reg <= 2'h0;
    end else begin
      tclk_meta_reg <= timer_clk_pin;
      tclk_sync_reg <= tclk_meta_reg;
      tclk_prev_reg <= tclk_sync_reg;
    end
  end

  // ****************************************
  // Comparator channels
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `CMP_NUM; gi++) begin : g_ch
      cmp_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_result(raw_result[gi]),
        .comparator_on(ctrl_a_reg[gi][`CTRL_A_ON_BIT]),
        .output_invert(ctrl_a_reg[gi][`CTRL_A_POL_BIT]),
        .timer_sync_enable(ctrl_a_reg[gi][`CTRL_A_SYNC_BIT]),
        .rise_irq_enable(ctrl_b_reg[gi][`CTRL_B_RISE_BIT]),
        .fall_irq_enable(ctrl_b_reg[gi][`CTRL_B_FALL_BIT]),
        .instr_tick(instr_tick),
        .timer_clk_fall(tclk_prev_reg[gi] & ~tclk_sync_reg[gi]),
        .compare_result(compare_result[gi]),
        .pin_result(pin_result[gi]),
        .sync_result(sync_result[gi]),
        .edge_event(edge_event[gi])
      );
    end
  endgenerate

  // ****************************************
  // Analog and consumer outputs
  // ****************************************
  function automatic logic [1:0] route_field(input logic [7:0] b, input int lsb);
    route_field = b[lsb +: 2];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_enable <= 2'h0;
      speed_select_out <= 2'h3;
      hysteresis_out <= 2'h0;
      plus_route <= 4'h0;
      minus_route <= 4'h0;
      inputs_connect <= 2'h0;
      result_pin_out <= 2'h0;
      result_pin_oe_n <= 2'h3;
      gate_source <= 2'h0;
      shutdown_source <= 2'h0;
    end else begin
      for (int i = 0; i < `CMP_NUM; i++) begin
        analog_enable[i] <= ctrl_a_reg[i][`CTRL_A_ON_BIT];
        speed_select_out[i] <= ctrl_a_reg[i][`CTRL_A_SP_BIT];
        hysteresis_out[i] <= ctrl_a_reg[i][`CTRL_A_HYS_BIT];
        plus_route[2*i +: 2] <= route_field(ctrl_b_reg[i], `CTRL_B_PCH_LSB);
        minus_route[2*i +: 2] <= route_field(ctrl_b_reg[i], `CTRL_B_NCH_LSB);
        inputs_connect[i] <= ctrl_a_reg[i][`CTRL_A_ON_BIT];
        // Override replaces port latch regardless of comparator_on
        result_pin_out[i] <= ctrl_a_reg[i][`CTRL_A_OE_BIT] ? pin_result[i]
                           : pincfg_reg[i][`PORT_LATCH_BIT];
        result_pin_oe_n[i] <= pincfg_reg[i][`PINCFG_DIR_BIT];
        gate_source[i] <= sync_result[i];
        shutdown_source[i] <= sync_result[i];
      end
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign wr_fire = (wr_state_reg == cmp_pkg::AXI_IDLE) && aw_held_reg && w_held_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      wr_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && wr_state_reg == cmp_pkg::AXI_IDLE;
      s_axi_wready <= !w_held_reg && !s_axi_wready && wr_state_reg == cmp_pkg::AXI_IDLE;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= cmp_pkg::AXI_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      unique case (wr_state_reg)
        cmp_pkg::AXI_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_hit(wr_addr) ? 2'h0 : 2'h2;
            wr_state_reg <= cmp_pkg::AXI_RESP;
          end
        end
        cmp_pkg::AXI_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= cmp_pkg::AXI_IDLE;
          end
        end
      endcase
    end
  end

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `CMP_FLAG_OFF) || (a == `CMP_MIRROR_OFF)
           || (a == `CMP_PINCFG_OFF) || (a == `CMP_PINCFG_OFF + 8'h04)
           || (a[7:5] == 3'h0 && a[3:0] == 4'(`CMP_CTRL_A_OFF))
           || (a[7:5] == 3'h0 && a[3:0] == 4'(`CMP_CTRL_B_OFF));
  endfunction

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `CMP_NUM; i++) begin
        ctrl_a_reg[i] <= `CTRL_A_RESET;
        ctrl_b_reg[i] <= `CTRL_B_RESET;
        pincfg_reg[i] <= `PINCFG_RESET;
      end
    end else if (wr_fire && wr_lane0) begin
      for (int i = 0; i < `CMP_NUM; i++) begin
        if (wr_addr == `CMP_CTRL_A_OFF + 8'(i) * `CMP_STRIDE) begin
          ctrl_a_reg[i] <= wr_data & `CTRL_A_WMASK;
        end
        if (wr_addr == `CMP_CTRL_B_OFF + 8'(i) * `CMP_STRIDE) begin
          ctrl_b_reg[i] <= wr_data & `CTRL_B_WMASK;
        end
        if (wr_addr == `CMP_PINCFG_OFF + 8'(i) * 8'h04) begin
          pincfg_reg[i] <= wr_data & 8'h03;
        end
      end
    end
  end

  // ****************************************
  // Interrupt flags: write one to clear
  // ****************************************
  assign flag_clear = (wr_fire && wr_lane0 && wr_addr == `CMP_FLAG_OFF) ? wr_data[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 2'h0;
      compare_irq_flag <= 2'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clear) | edge_event;
      compare_irq_flag <= (flag_reg & ~flag_clear) | edge_event;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    read_mux = 8'h00;
    for (int i = 0; i < `CMP_NUM; i++) begin
      if (a == `CMP_CTRL_A_OFF + 8'(i) * `CMP_STRIDE) begin
        read_mux = ctrl_a_reg[i] | (8'(compare_result[i]) << `CTRL_A_RESULT_BIT);
      end
      if (a == `CMP_CTRL_B_OFF + 8'(i) * `CMP_STRIDE) begin
        read_mux = ctrl_b_reg[i];
      end
      if (a == `CMP_PINCFG_OFF + 8'(i) * 8'h04) begin
        read_mux = pincfg_reg[i];
      end
    end
    if (a == `CMP_FLAG_OFF) begin
      read_mux = {6'h00, flag_reg};
    end
    if (a == `CMP_MIRROR_OFF) begin
      read_mux = {6'h00, compare_result};
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= cmp_pkg::AXI_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      unique case (rd_state_reg)
        cmp_pkg::AXI_IDLE: begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, read_mux(s_axi_araddr[7:0])};
            s_axi_rresp <= reg_hit(s_axi_araddr[7:0]) ? 2'h0 : 2'h2;
            rd_state_reg <= cmp_pkg::AXI_RESP;
          end
        end
        cmp_pkg::AXI_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_reg <= cmp_pkg::AXI_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ---- verif/analog_comparator_control_assertions.sv ----
// Purpose: port-level checks of the comparator control block
// Assumes: one clock domain, aresetn synchronous active low
// Notes: bound to every instance of the top module
module acc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] analog_enable,
  input wire logic [1:0] speed_select_out,
  input wire logic [1:0] inputs_connect,
  input wire logic [1:0] result_pin_oe_n,
  input wire logic [1:0] gate_source,
  input wire logic [1:0] shutdown_source,
  input wire logic [1:0] compare_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since the last write data beat, saturating at 7
  logic [2:0] since_wr;
  always_ff @(posedge aclk) begin
    if (!aresetn) since_wr <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) since_wr <= 3'h0;
    else if (since_wr != 3'h7) since_wr <= since_wr + 3'h1;
  end
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_reset_values: assert property ($rose(aresetn) |-> speed_select_out == 2'h3 && result_pin_oe_n == 2'h3
    && analog_enable == 2'h0 && compare_irq_flag == 2'h0) else $error("bad reset value");
  a_inputs_follow_on: assert property (inputs_connect == analog_enable)
    else $error("input paths not tied to enable");
  a_gate_eq_shutdown: assert property (gate_source == shutdown_source)
    else $error("gate and shutdown differ");
  a_ctrl_needs_write: assert property (!$stable({analog_enable, speed_select_out, result_pin_oe_n})
    |-> since_wr < 3'h5) else $error("control changed without write");
  a_flag_sw_clear: assert property ($fell(compare_irq_flag[0]) || $fell(compare_irq_flag[1])
    |-> since_wr < 3'h6) else $error("flag cleared without write");
endmodule

bind analog_comparator_control acc_checker acc_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .analog_enable, .speed_select_out, .inputs_connect, .result_pin_oe_n, .gate_source,
  .shutdown_source, .compare_irq_flag);

// ---- verif/analog_source_model.sv ----
// Purpose: behavioural analog macro: two comparators and the timer clock, passed straight through from timer_drive
// Assumes: voltages given as unsigned millivolt codes
// Notes: low-power mode answers slowly; a disabled comparator output is garbage
module analog_source_model (
  input wire logic [1:0][11:0] plus_mv,
  input wire logic [1:0][11:0] minus_mv,
  input wire logic [1:0] analog_enable,
  input wire logic [1:0] inputs_connect,
  input wire logic [1:0] speed_select_out,
  input wire logic [1:0] timer_drive,
  output logic [1:0] raw_result,
  output logic [1:0] timer_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial raw_result = 2'h0;
  assign timer_clk_pin = timer_drive;
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    always @(plus_mv[i] or minus_mv[i] or analog_enable[i] or inputs_connect[i] or speed_select_out[i]) begin
      if (analog_enable[i] && inputs_connect[i])
        raw_result[i] <= #(speed_select_out[i] ? 30 : 120) (plus_mv[i] > minus_mv[i]);
      else
        raw_result[i] <= #5 ~raw_result[i];
    end
  end
endmodule

// ---- verif/analog_comparator_control_tb_top.sv ----
// Purpose: register-level test of the comparator control block
// Assumes: AXI4-Lite master tasks, 40 MHz clock
// Notes: waits after writes cover the two-flop sync and the 4-cycle latch
module analog_comparator_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, e;
  logic [1:0] s_axi_bresp, s_axi_rresp, raw_result, timer_clk_pin, analog_enable, speed_select_out, hysteresis_out;
  logic [1:0] inputs_connect, result_pin_out, result_pin_oe_n, gate_source, shutdown_source, compare_irq_flag;
  logic [3:0] plus_route, minus_route;
  logic [1:0][11:0] plus_mv = '0, minus_mv = {12'h200, 12'h200};
  logic [1:0] timer_drive = 2'h0;
  int mismatches = 0, cmp_count = 0;
  always #12.5 aclk = ~aclk;
  analog_comparator_control analog_comparator_control_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .raw_result, .timer_clk_pin, .analog_enable, .speed_select_out, .hysteresis_out, .plus_route,
    .minus_route, .inputs_connect, .result_pin_out, .result_pin_oe_n, .gate_source, .shutdown_source,
    .compare_irq_flag);
  analog_source_model analog_source_model_inst (.plus_mv, .minus_mv, .analog_enable, .inputs_connect,
    .speed_select_out, .timer_drive, .raw_result, .timer_clk_pin);
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 60) check(32'h0, 32'h1);
      if (n > 60) report_and_stop();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 60) check(32'h0, 32'h1);
      if (n > 60) report_and_stop();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check({24'h0, speed_select_out, result_pin_oe_n, analog_enable, compare_irq_flag}, 32'hf0);
    rd(8'h00, 32'h04);
    rd(8'h14, 32'h00);
    rd(8'h48, 32'h01);
    rd(8'h3c, 32'h0, 2'h2);
    wr(8'h3c, 32'hff, 2'h2);
    for (int i = 0; i < 2; i++) begin
      wr(8'(16 * i), 32'h86);
      for (int s = 0; s < 4; s++) begin
        wr(8'(16 * i + 4), 32'(16 * s + 3 - s));
        settle(3);
        check({28'h0, plus_route[2*i+:2], minus_route[2*i+:2]}, 32'(4 * s + 3 - s));
      end
    end
    check({26'h0, analog_enable, hysteresis_out, inputs_connect}, 32'h3f);
    wr(8'h10, 32'h00);
    settle(3);
    check({26'h0, analog_enable, speed_select_out, inputs_connect}, 32'h15);
    check({30'h0, hysteresis_out}, 32'h1);
    rd(8'h14, 32'h30);
    wr(8'h10, 32'h48);
    rd(8'h10, 32'h00);
    wr(8'h04, 32'h00);
    for (int k = 0; k < 4; k++) begin
      plus_mv[0] <= k[0] ? 12'h300 : 12'h100;
      wr(8'h00, k[1] ? 32'h94 : 32'h84);
      settle(12);
      e = k[0] ^ k[1];
      rd(8'h00, (k[1] ? 32'h94 : 32'h84) | {25'h0, e, 6'h0});
      rd(8'h44, {31'h0, e});
      check({30'h0, gate_source[0], shutdown_source[0]}, {30'h0, e, e});
    end
    wr(8'h00, 32'h84);
    wr(8'h04, 32'h80);
    plus_mv[0] <= 12'h100;
    settle(12);
    check({30'h0, compare_irq_flag}, 32'h0);
    plus_mv[0] <= 12'h300;
    settle(12);
    rd(8'h40, 32'h1);
    wr(8'h40, 32'h1);
    settle(3);
    check({30'h0, compare_irq_flag}, 32'h0);
    wr(8'h00, 32'h04);
    wr(8'h00, 32'h14);
    settle(12);
    check({30'h0, compare_irq_flag}, 32'h1);
    wr(8'h04, 32'h40);
    wr(8'h40, 32'h1);
    wr(8'h00, 32'h04);
    settle(12);
    check({30'h0, compare_irq_flag}, 32'h1);
    wr(8'h00, 32'h84);
    wr(8'h48, 32'h00);
    settle(12);
    check({30'h0, result_pin_out[0], result_pin_oe_n[0]}, 32'h0);
    wr(8'h00, 32'ha4);
    settle(6);
    check({30'h0, result_pin_out[0], result_pin_oe_n[0]}, 32'h2);
    wr(8'h48, 32'h02);
    wr(8'h00, 32'h24);
    settle(12);
    check({30'h0, result_pin_out[0], result_pin_oe_n[0]}, 32'h0);
    wr(8'h00, 32'h04);
    settle(6);
    check({30'h0, result_pin_out[0], result_pin_oe_n[0]}, 32'h2);
    wr(8'h00, 32'h85);
    settle(12);
    timer_drive[0] <= 1'b1;
    settle(6);
    timer_drive[0] <= 1'b0;
    settle(12);
    check({31'h0, gate_source[0]}, 32'h1);
    plus_mv[0] <= 12'h100;
    settle(16);
    check({31'h0, gate_source[0]}, 32'h1);
    timer_drive[0] <= 1'b1;
    settle(12);
    check({31'h0, gate_source[0]}, 32'h1);
    timer_drive[0] <= 1'b0;
    settle(12);
    check({31'h0, gate_source[0]}, 32'h0);
    aresetn <= 1'b0;
    settle(4);
    aresetn <= 1'b1;
    check({24'h0, speed_select_out, result_pin_oe_n, analog_enable, compare_irq_flag}, 32'hf0);
    rd(8'h00, 32'h04);
    report_and_stop();
  end
endmodule
